/* File: rtl/ucb_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb, one word per register
// Notes:   shared location writes route on select bit, reads on read order
`ifndef UCB_CONSTS_SVH
`define UCB_CONSTS_SVH
// register byte offsets
`define UCB_OFS_DATA    8'h00
`define UCB_OFS_STATUS  8'h04
`define UCB_OFS_CTRL    8'h08
`define UCB_OFS_SHARED  8'h0c
`define UCB_OFS_BAUDL   8'h10
// rx_tx_control fields
`define UCB_CTRL_RXIE   7
`define UCB_CTRL_TXIE   6
`define UCB_CTRL_EMPIE  5
`define UCB_CTRL_RXON   4
`define UCB_CTRL_TXON   3
`define UCB_CTRL_CSZ2   2
`define UCB_CTRL_TX9    0
// frame_format_config fields (msb of multi-bit fields)
`define UCB_FMT_SEL     7
`define UCB_FMT_SYNC    6
`define UCB_FMT_PAR     5
`define UCB_FMT_STOP    3
`define UCB_FMT_CSZ     2
`define UCB_FMT_POL     0
// line_status fields
`define UCB_STAT_FILT   0
`define UCB_STAT_TXDONE 6
// reset values
`define UCB_CTRL_RESET  8'h00
`define UCB_FMT_RESET   7'h06
`define UCB_BAUD_RESET  12'h000
// bit timing in baud ticks
`define UCB_ASYNC_WRAP  4'hf
`define UCB_ASYNC_MID   4'h7
`define UCB_SYNC_WRAP   4'h1
`endif

/* File: rtl/ucb_pkg.sv */
// Purpose: shared types and frame helpers
// Assumes: char code and parity mode as in the format fields
// Notes:   reserved char codes fall back to nine bits
package ucb_pkg;
  typedef enum logic [2:0] {
    UCB_IDLE  = 3'b000,
    UCB_START = 3'b001,
    UCB_DATA  = 3'b010,
    UCB_PAR   = 3'b011,
    UCB_STOP1 = 3'b100,
    UCB_STOP2 = 3'b101
  } ucb_state_type;

  // data bits per frame from the 3-bit size code
  function automatic logic [3:0] ucb_char_bits(input logic [2:0] code);
    return code[2] ? 4'h9 : ({2'b00, code[1:0]} + 4'h5);
  endfunction

  // parity active only for the two enabled codes
  function automatic logic ucb_parity_on(input logic [1:0] mode);
    return mode[1];
  endfunction

  // parity bit over the first n data bits
  function automatic logic ucb_parity(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        p = p ^ d[i];
    return p;
  endfunction
endpackage

/* File: rtl/ucb_link_if.sv */
// Purpose: serial lines between the transceiver and its remote end
// Assumes: both ends on pclk; lines sampled through synchronisers
// Notes:   serial clock made by the device in synchronous mode
`timescale 1ns/1ps
interface ucb_link_if;
  logic dev_txd;
  logic far_txd;
  logic sync_serial_clock;
  modport dev (output dev_txd, output sync_serial_clock, input far_txd);
  modport far (input dev_txd, input sync_serial_clock, output far_txd);
endinterface

/* File: rtl/ucb_device.sv */
// Purpose: control, frame format and baud divisor of the transceiver
// Assumes: apb slave with no wait states; ce freezes all state
// Notes:   single-level receive buffer, irq lines registered
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ucb_consts.svh"
module ucb_device
  import ucb_pkg::*;
(
  input  logic        pclk,
  input  logic        presetn,
  input  logic        ce,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        global_irq_on,
  input  logic        port_txd_level,
  output logic        tx_pin_owned,
  output logic        rx_pin_owned,
  output logic        rx_done_irq,
  output logic        tx_done_irq,
  output logic        tx_empty_irq,
  ucb_link_if.dev     link
);
  logic [7:0]    ctrl_reg, ctrl_next;
  logic [6:0]    fmt_reg, fmt_next;
  logic [11:0]   baud_reg, baud_next;
  logic          filter_reg, filter_next, shared_rd_reg, shared_rd_next;
  logic          pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0]   prdata_reg, prdata_next, rd_value;
  logic [2:0]    irq_reg, irq_next;
  logic          rxd_meta_reg, rxd_reg;
  logic [11:0]   cnt_reg, cnt_next;
  logic [3:0]    tph_reg, tph_next, rph_reg, rph_next;
  logic          xck_reg, xck_next, txd_reg, txd_next;
  ucb_state_type ts_reg, ts_next, rs_reg, rs_next;
  logic [3:0]    tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
  logic [8:0]    tsh_reg, tsh_next, tbuf_reg, tbuf_next, rsh_reg, rsh_next;
  logic [8:0]    rdat_reg, rdat_next;
  logic          tfull_reg, tfull_next, tact_reg, tact_next, tline_reg, tline_next;
  logic          tdone_reg, tdone_next, rfull_reg, rfull_next, rpar_reg, rpar_next;
  logic          ferr_reg, ferr_next, ovr_reg, ovr_next, perr_reg, perr_next;
  logic          setup, access, wr_data, rd_data, wr_baudl, clr_tdone, mapped;
  logic          sync, par_on, par_odd, nine, tick, tx_edge, rx_sample, rxd;
  logic [3:0]    nbits, wrap;

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // bus strobes: effects land at the completing access edge
  assign setup     = psel & ~penable;
  assign access    = psel & penable & pready_reg;
  assign wr_data   = access & pwrite & at(paddr, `UCB_OFS_DATA);
  assign rd_data   = access & ~pwrite & at(paddr, `UCB_OFS_DATA);
  assign wr_baudl  = access & pwrite & at(paddr, `UCB_OFS_BAUDL);
  assign clr_tdone = access & pwrite & at(paddr, `UCB_OFS_STATUS) & pwdata[`UCB_STAT_TXDONE];
  assign mapped    = at(paddr, `UCB_OFS_DATA) | at(paddr, `UCB_OFS_STATUS)
                   | at(paddr, `UCB_OFS_CTRL) | at(paddr, `UCB_OFS_SHARED)
                   | at(paddr, `UCB_OFS_BAUDL);

  // frame settings decoded from the format fields and the control size bit
  assign nbits   = ucb_char_bits({ctrl_reg[`UCB_CTRL_CSZ2], fmt_reg[`UCB_FMT_CSZ -: 2]});
  assign nine    = nbits == 4'h9;
  assign sync    = fmt_reg[`UCB_FMT_SYNC];
  assign par_on  = ucb_parity_on(fmt_reg[`UCB_FMT_PAR -: 2]);
  assign par_odd = fmt_reg[`UCB_FMT_PAR - 1];
  assign wrap    = sync ? `UCB_SYNC_WRAP : `UCB_ASYNC_WRAP;
  assign tick    = cnt_reg == 12'h000;
  assign tx_edge = tick && tph_reg == wrap;
  assign rx_sample = sync ? (tick && tph_reg == 4'h0) : (tick && rph_reg == `UCB_ASYNC_MID);
  assign rxd     = rxd_reg;

  // register file, read mux and interrupt gating
  always_comb
  begin
    ctrl_next      = ctrl_reg;
    fmt_next       = fmt_reg;
    baud_next      = baud_reg;
    filter_next    = filter_reg;
    shared_rd_next = shared_rd_reg;
    pready_next    = setup;
    prdata_next    = prdata_reg;
    pslverr_next   = pslverr_reg;
    rd_value       = 32'h0000_0000;
    case (paddr)
      `UCB_OFS_DATA:   rd_value[7:0] = rdat_reg[7:0];
      `UCB_OFS_STATUS: rd_value[7:0] = {rfull_reg, tdone_reg, ~tfull_reg, ferr_reg,
                                        ovr_reg, perr_reg, 1'b0, filter_reg};
      `UCB_OFS_CTRL:   rd_value[7:0] = {ctrl_reg[7:2], rdat_reg[8], ctrl_reg[0]};
      `UCB_OFS_SHARED: rd_value[7:0] = shared_rd_reg ? {1'b1, fmt_reg}
                                                     : {4'h0, baud_reg[11:8]};
      `UCB_OFS_BAUDL:  rd_value[7:0] = baud_reg[7:0];
      default:         rd_value = 32'h0000_0000;
    endcase
    if (setup)
    begin
      prdata_next  = rd_value;
      pslverr_next = ~mapped;
    end
    if (access)
      shared_rd_next = ~pwrite & at(paddr, `UCB_OFS_SHARED);
    else if (!psel)
      shared_rd_next = 1'b0;
    if (access && pwrite)
    begin
      case (paddr)
        `UCB_OFS_CTRL:   ctrl_next = pwdata[7:0];
        `UCB_OFS_STATUS: filter_next = pwdata[`UCB_STAT_FILT];
        `UCB_OFS_SHARED:
          if (pwdata[`UCB_FMT_SEL])
            fmt_next = pwdata[6:0];
          else
            baud_next[11:8] = pwdata[3:0];
        `UCB_OFS_BAUDL:  baud_next[7:0] = pwdata[7:0];
        default:         baud_next = baud_reg;
      endcase
    end
    irq_next[2] = ctrl_reg[`UCB_CTRL_RXIE] & global_irq_on & rfull_reg;
    irq_next[1] = ctrl_reg[`UCB_CTRL_TXIE] & global_irq_on & tdone_reg;
    irq_next[0] = ctrl_reg[`UCB_CTRL_EMPIE] & global_irq_on & ~tfull_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg      <= `UCB_CTRL_RESET;
      fmt_reg       <= `UCB_FMT_RESET;
      baud_reg      <= `UCB_BAUD_RESET;
      filter_reg    <= 1'b0;
      shared_rd_reg <= 1'b0;
      pready_reg    <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      pslverr_reg   <= 1'b0;
      irq_reg       <= 3'h0;
    end
    else if (ce)
    begin
      ctrl_reg      <= ctrl_next;
      fmt_reg       <= fmt_next;
      baud_reg      <= baud_next;
      filter_reg    <= filter_next;
      shared_rd_reg <= shared_rd_next;
      pready_reg    <= pready_next;
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
      irq_reg       <= irq_next;
    end
  end

  // prescaler, bit phases, transmitter and receiver
  always_comb
  begin
    cnt_next = wr_baudl ? {baud_reg[11:8], pwdata[7:0]}
             : (tick ? baud_reg : cnt_reg - 12'h001);
    tph_next = tick ? (tx_edge ? 4'h0 : tph_reg + 4'h1) : tph_reg;
    rph_next = tick ? rph_reg + 4'h1 : rph_reg;
    xck_next = sync & ((tph_next == 4'h0) ^ fmt_reg[`UCB_FMT_POL]);
    ts_next = ts_reg;  tcnt_next = tcnt_reg;  tsh_next = tsh_reg;  tline_next = tline_reg;
    tbuf_next = tbuf_reg;  tfull_next = tfull_reg;  tdone_next = tdone_reg & ~clr_tdone;
    if (wr_data && !tfull_reg)
    begin
      tbuf_next  = {ctrl_reg[`UCB_CTRL_TX9], pwdata[7:0]};
      tfull_next = 1'b1;
    end
    if (tx_edge)
    begin
      case (ts_reg)
        UCB_IDLE:
          if (tact_reg && tfull_reg)
          begin
            tsh_next = tbuf_reg;  tfull_next = 1'b0;  ts_next = UCB_START;  tline_next = 1'b0;
          end
        UCB_START:
        begin
          ts_next = UCB_DATA;  tcnt_next = 4'h0;  tline_next = tsh_reg[0];
        end
        UCB_DATA:
          if (tcnt_reg == nbits - 4'h1)
          begin
            ts_next    = par_on ? UCB_PAR : UCB_STOP1;
            tline_next = par_on ? ucb_parity(tsh_reg, nbits, par_odd) : 1'b1;
          end
          else
          begin
            tcnt_next  = tcnt_reg + 4'h1;
            tline_next = tsh_reg[tcnt_reg + 4'h1];
          end
        UCB_PAR:
        begin
          ts_next = UCB_STOP1;  tline_next = 1'b1;
        end
        UCB_STOP1:
          if (fmt_reg[`UCB_FMT_STOP])
            ts_next = UCB_STOP2;
          else
          begin
            ts_next = UCB_IDLE;  tdone_next = tdone_next | ~tfull_next;
          end
        default:
        begin
          ts_next = UCB_IDLE;  tdone_next = tdone_next | ~tfull_next;
        end
      endcase
    end
    tact_next = ctrl_reg[`UCB_CTRL_TXON]
              | (tact_reg & ((ts_reg != UCB_IDLE) | tfull_reg));
    txd_next  = tact_next ? tline_next : port_txd_level;
    rs_next = rs_reg;  rcnt_next = rcnt_reg;  rsh_next = rsh_reg;  rpar_next = rpar_reg;
    rdat_next = rdat_reg;  rfull_next = rfull_reg;
    ferr_next = ferr_reg;  ovr_next = ovr_reg;  perr_next = perr_reg;
    if (rd_data)
    begin
      rfull_next = 1'b0;  ferr_next = 1'b0;  ovr_next = 1'b0;  perr_next = 1'b0;
    end
    if (!ctrl_reg[`UCB_CTRL_RXON])
    begin
      rs_next = UCB_IDLE;  rfull_next = 1'b0;
      ferr_next = 1'b0;  ovr_next = 1'b0;  perr_next = 1'b0;
    end
    else
    begin
      case (rs_reg)
        UCB_IDLE:
          if (sync ? (rx_sample && !rxd) : !rxd)
          begin
            rs_next = sync ? UCB_DATA : UCB_START;
            rcnt_next = 4'h0;  rsh_next = 9'h000;  rph_next = 4'h0;
          end
        UCB_START:
          if (rx_sample)
            rs_next = rxd ? UCB_IDLE : UCB_DATA;
        UCB_DATA:
          if (rx_sample)
          begin
            rsh_next[rcnt_reg] = rxd;
            if (rcnt_reg == nbits - 4'h1)
              rs_next = par_on ? UCB_PAR : UCB_STOP1;
            else
              rcnt_next = rcnt_reg + 4'h1;
          end
        UCB_PAR:
          if (rx_sample)
          begin
            rpar_next = rxd;  rs_next = UCB_STOP1;
          end
        default:
          if (rx_sample)
          begin
            rs_next = UCB_IDLE;
            if (!filter_reg || (nine ? rsh_reg[8] : rxd))
            begin
              if (rfull_next)
                ovr_next = 1'b1;
              else
              begin
                rdat_next = rsh_reg;  rfull_next = 1'b1;  ferr_next = ~rxd;
                perr_next = par_on & (ucb_parity(rsh_reg, nbits, par_odd) != rpar_reg);
              end
            end
          end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_reg <= 1'b1;  rxd_reg <= 1'b1;
      cnt_reg <= 12'h000;  tph_reg <= 4'h0;  rph_reg <= 4'h0;
      xck_reg <= 1'b0;  txd_reg <= 1'b1; // idle level, no false start
      ts_reg <= UCB_IDLE;  tcnt_reg <= 4'h0;  tsh_reg <= 9'h000;  tline_reg <= 1'b1;
      tbuf_reg <= 9'h000;  tfull_reg <= 1'b0;  tact_reg <= 1'b0;  tdone_reg <= 1'b0;
      rs_reg <= UCB_IDLE;  rcnt_reg <= 4'h0;  rsh_reg <= 9'h000;  rpar_reg <= 1'b0;
      rdat_reg <= 9'h000;  rfull_reg <= 1'b0;
      ferr_reg <= 1'b0;  ovr_reg <= 1'b0;  perr_reg <= 1'b0;
    end
    else if (ce)
    begin
      rxd_meta_reg <= link.far_txd;  rxd_reg <= rxd_meta_reg;
      cnt_reg <= cnt_next;  tph_reg <= tph_next;  rph_reg <= rph_next;
      xck_reg <= xck_next;  txd_reg <= txd_next;
      ts_reg <= ts_next;  tcnt_reg <= tcnt_next;  tsh_reg <= tsh_next;  tline_reg <= tline_next;
      tbuf_reg <= tbuf_next;  tfull_reg <= tfull_next;  tact_reg <= tact_next;
      tdone_reg <= tdone_next;
      rs_reg <= rs_next;  rcnt_reg <= rcnt_next;  rsh_reg <= rsh_next;  rpar_reg <= rpar_next;
      rdat_reg <= rdat_next;  rfull_reg <= rfull_next;
      ferr_reg <= ferr_next;  ovr_reg <= ovr_next;  perr_reg <= perr_next;
    end
  end

  // outputs straight from flops
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign tx_pin_owned = tact_reg;
  assign rx_pin_owned = ctrl_reg[`UCB_CTRL_RXON];
  assign rx_done_irq  = irq_reg[2];
  assign tx_done_irq  = irq_reg[1];
  assign tx_empty_irq = irq_reg[0];
  assign link.dev_txd = txd_reg;
  assign link.sync_serial_clock = xck_reg;
endmodule // ucb_device

/* File: rtl/ucb_far_end.sv */
// Purpose: remote transceiver facing the device's serial lines
// Assumes: same frame settings as the device; slave to its serial clock
// Notes:   one frame buffered each way; idle gap after every frame
`timescale 1ns/1ps
`include "ucb_consts.svh"
module ucb_far_end
  import ucb_pkg::*;
(
  input  logic        pclk,
  input  logic        presetn,
  input  logic        ce,
  input  logic [2:0]  cfg_char_code,
  input  logic [1:0]  cfg_parity,
  input  logic        cfg_two_stop,
  input  logic        cfg_sync,
  input  logic        cfg_polarity,
  input  logic [11:0] cfg_divisor,
  input  logic        send_valid,
  input  logic [8:0]  send_data,
  output logic        send_ready,
  output logic        recv_valid,
  output logic [8:0]  recv_data,
  output logic        recv_parity_bad,
  output logic        recv_frame_bad,
  ucb_link_if.far     link
);
  logic [1:0]    rx_meta_reg, rx_sync_reg;
  logic          ck_prev_reg, ready_reg, ready_next, valid_reg, valid_next;
  logic          pbad_reg, pbad_next, fbad_reg, fbad_next, line_reg, line_next, pend_reg, pend_next;
  logic [11:0]   cnt_reg, cnt_next;
  logic [3:0]    tph_reg, tph_next, rph_reg, rph_next, tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
  ucb_state_type ts_reg, ts_next, rs_reg, rs_next;
  logic [8:0]    tsh_reg, tsh_next, rsh_reg, rsh_next, data_reg, data_next;
  logic          rpar_reg, rpar_next, tick, ck_edge, tx_step, rx_sample, rxd, par_on;
  logic [3:0]    nbits;

  assign nbits   = ucb_char_bits(cfg_char_code);
  assign par_on  = ucb_parity_on(cfg_parity);
  assign rxd     = rx_sync_reg[0];
  assign tick    = cnt_reg == 12'h000;
  assign ck_edge = rx_sync_reg[1] != ck_prev_reg;
  assign tx_step = cfg_sync ? (ck_edge && rx_sync_reg[1] != cfg_polarity)
                            : (tick && tph_reg == `UCB_ASYNC_WRAP);
  assign rx_sample = cfg_sync ? (ck_edge && rx_sync_reg[1] == cfg_polarity)
                              : (tick && rph_reg == `UCB_ASYNC_MID);

  // frame engines in both directions
  always_comb
  begin
    cnt_next = tick ? cfg_divisor : cnt_reg - 12'h001;
    tph_next = tick ? tph_reg + 4'h1 : tph_reg;
    rph_next = tick ? rph_reg + 4'h1 : rph_reg;
    ts_next = ts_reg;  tcnt_next = tcnt_reg;  tsh_next = tsh_reg;  line_next = line_reg;
    pend_next = pend_reg;
    if (send_valid && ready_reg)
    begin
      pend_next = 1'b1;  tsh_next = send_data;
    end
    if (tx_step)
    begin
      case (ts_reg)
        UCB_IDLE:
          if (pend_reg)
          begin
            pend_next = 1'b0;  ts_next = UCB_START;  line_next = 1'b0;
          end
        UCB_START:
        begin
          ts_next = UCB_DATA;  tcnt_next = 4'h0;  line_next = tsh_reg[0];
        end
        UCB_DATA:
          if (tcnt_reg == nbits - 4'h1)
          begin
            ts_next   = par_on ? UCB_PAR : UCB_STOP1;
            line_next = par_on ? ucb_parity(tsh_reg, nbits, cfg_parity[0]) : 1'b1;
          end
          else
          begin
            tcnt_next = tcnt_reg + 4'h1;  line_next = tsh_reg[tcnt_reg + 4'h1];
          end
        UCB_PAR:
        begin
          ts_next = UCB_STOP1;  line_next = 1'b1;
        end
        UCB_STOP1: ts_next = cfg_two_stop ? UCB_STOP2 : UCB_IDLE;
        default:   ts_next = UCB_IDLE;
      endcase
    end
    ready_next = ~pend_next & (ts_next == UCB_IDLE);
    rs_next = rs_reg;  rcnt_next = rcnt_reg;  rsh_next = rsh_reg;  rpar_next = rpar_reg;
    data_next = data_reg;  valid_next = 1'b0;  pbad_next = pbad_reg;  fbad_next = fbad_reg;
    case (rs_reg)
      UCB_IDLE:
        if (cfg_sync ? (rx_sample && !rxd) : !rxd)
        begin
          rs_next = cfg_sync ? UCB_DATA : UCB_START;
          rcnt_next = 4'h0;  rsh_next = 9'h000;  rph_next = 4'h0;
        end
      UCB_START:
        if (rx_sample)
          rs_next = rxd ? UCB_IDLE : UCB_DATA;
      UCB_DATA:
        if (rx_sample)
        begin
          rsh_next[rcnt_reg] = rxd;
          if (rcnt_reg == nbits - 4'h1)
            rs_next = par_on ? UCB_PAR : UCB_STOP1;
          else
            rcnt_next = rcnt_reg + 4'h1;
        end
      UCB_PAR:
        if (rx_sample)
        begin
          rpar_next = rxd;  rs_next = UCB_STOP1;
        end
      default:
        if (rx_sample)
        begin
          rs_next = UCB_IDLE;  data_next = rsh_reg;  valid_next = 1'b1;  fbad_next = ~rxd;
          pbad_next = par_on & (ucb_parity(rsh_reg, nbits, cfg_parity[0]) != rpar_reg);
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta_reg <= 2'b11;  rx_sync_reg <= 2'b11;  ck_prev_reg <= 1'b1;
      cnt_reg <= 12'h000;  tph_reg <= 4'h0;  rph_reg <= 4'h0;
      ts_reg <= UCB_IDLE;  tcnt_reg <= 4'h0;  tsh_reg <= 9'h000;  line_reg <= 1'b1;
      pend_reg <= 1'b0;  ready_reg <= 1'b0;
      rs_reg <= UCB_IDLE;  rcnt_reg <= 4'h0;  rsh_reg <= 9'h000;  rpar_reg <= 1'b0;
      data_reg <= 9'h000;  valid_reg <= 1'b0;  pbad_reg <= 1'b0;  fbad_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_meta_reg <= {link.sync_serial_clock, link.dev_txd};
      rx_sync_reg <= rx_meta_reg;  ck_prev_reg <= rx_sync_reg[1];
      cnt_reg <= cnt_next;  tph_reg <= tph_next;  rph_reg <= rph_next;
      ts_reg <= ts_next;  tcnt_reg <= tcnt_next;  tsh_reg <= tsh_next;  line_reg <= line_next;
      pend_reg <= pend_next;  ready_reg <= ready_next;
      rs_reg <= rs_next;  rcnt_reg <= rcnt_next;  rsh_reg <= rsh_next;  rpar_reg <= rpar_next;
      data_reg <= data_next;  valid_reg <= valid_next;  pbad_reg <= pbad_next;
      fbad_reg <= fbad_next;
    end
  end

  assign send_ready      = ready_reg;
  assign recv_valid      = valid_reg;
  assign recv_data       = data_reg;
  assign recv_parity_bad = pbad_reg;
  assign recv_frame_bad  = fbad_reg;
  assign link.far_txd    = line_reg;
endmodule // ucb_far_end

/* File: bench/ucb_link_checker.sv */
// Purpose: register-bus and pin checks beside the two ends
// Assumes: one pclk domain, async active-low reset
// Notes:   sees device ports and the transmit line only
`timescale 1ns/1ps
`include "ucb_consts.svh"
module ucb_link_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        global_irq_on,
  input wire logic        port_txd_level,
  input wire logic        tx_pin_owned,
  input wire logic        rx_pin_owned,
  input wire logic        rx_done_irq,
  input wire logic        tx_done_irq,
  input wire logic        tx_empty_irq,
  input wire logic        dev_txd
);
  // accepted control write and shared-location read
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == `UCB_OFS_CTRL;
  wire sh_rd   = psel && pready && !pwrite && paddr == `UCB_OFS_SHARED;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // interrupts only with the global flag set
  AST_RX_IRQ: assert property (rx_done_irq |-> $past(global_irq_on))
    else $error("receive irq without global flag");
  AST_TX_IRQ: assert property (tx_done_irq |-> $past(global_irq_on))
    else $error("transmit irq without global flag");
  AST_EMPTY_IRQ: assert property (tx_empty_irq |-> $past(global_irq_on))
    else $error("empty irq without global flag");
  // receive ownership and transmit takeover follow control writes; released transmit pin at port level
  AST_RX_OWN: assert property ($changed(rx_pin_owned) |->
    $past(ctrl_wr) && $past(pwdata[4]) == rx_pin_owned) else $error("receiver ownership");
  AST_TX_OWN: assert property ($rose(tx_pin_owned) |->
    $past(ctrl_wr, 2) && $past(pwdata[3], 2)) else $error("transmitter ownership");
  AST_TXD_PORT: assert property (!tx_pin_owned && $past(!tx_pin_owned) && $past(presetn) |->
    dev_txd == $past(port_txd_level)) else $error("released pin not port level");
  // shared location read order
  AST_BAUDH_READ: assert property (sh_rd && !$past(psel, 2) |-> !prdata[7])
    else $error("single shared read not baud high");
  AST_FMT_READ: assert property (sh_rd && $past(sh_rd, 2) |-> prdata[7])
    else $error("second shared read not format");
  cover property ($fell(tx_pin_owned));
  cover property (rx_done_irq);
  cover property (sh_rd && $past(sh_rd, 2));
endmodule // ucb_link_checker

/* File: bench/tb.sv */
// Purpose: drives the device over apb and the far end over its user side
// Assumes: divisor 1, asynchronous frames; divisor 6 for the last, synchronous frame
// Notes:   sizes and parity modes walked from a table
`timescale 1ns/1ps
`include "ucb_consts.svh"
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, global_irq_on = 1'b1, port_txd_level = 1'b1, send_valid = 1'b0;
  logic        cfg_two_stop = 1'b0, cfg_sync = 1'b0, cfg_polarity = 1'b0;
  logic        pready, pslverr, tx_pin_owned, rx_pin_owned, rx_done_irq, tx_done_irq;
  logic        tx_empty_irq, send_ready, recv_valid, recv_parity_bad, recv_frame_bad;
  logic [1:0]  cfg_parity = 2'h0;
  logic [2:0]  cfg_char_code = 3'h3;
  logic [7:0]  paddr = 8'h00;
  logic [8:0]  send_data = 9'h1ca, recv_data, mask;
  logic [11:0] cfg_divisor = 12'h001;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0]  pars [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  int          checks = 0, miscompares = 0, n;
  ucb_link_if link ();
  ucb_device ucb_device_i (.link(link), .*);
  ucb_far_end ucb_far_end_i (.link(link), .*);
  ucb_link_checker ucb_link_checker_i (.dev_txd(link.dev_txd), .*);
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; k keeps psel up for a back-to-back access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    penable <= 1'b0;
    if (!k)
    begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic k = 1'b0);
    apb(1'b0, a, 32'h0, k);
    check(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  // far end takes one frame for its transmitter
  task automatic far_send;
    send_valid <= 1'b1;
    do @(posedge pclk); while (send_ready !== 1'b1);
    send_valid <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    give_verdict;
  end
  // reset, register checks, then frames both ways per format
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`UCB_OFS_CTRL, 32'h00);
    rd(`UCB_OFS_STATUS, 32'h20);
    rd(`UCB_OFS_SHARED, 32'h00, 1'b1);
    rd(`UCB_OFS_SHARED, 32'h86);
    wr(`UCB_OFS_SHARED, 32'h05);
    rd(`UCB_OFS_SHARED, 32'h05);
    wr(`UCB_OFS_SHARED, 32'h00);
    wr(`UCB_OFS_BAUDL, 32'h01);
    rd(`UCB_OFS_BAUDL, 32'h01);
    rd(8'h20, 32'h00);
    check(32'(pslverr), 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      cfg_char_code <= codes[i];
      cfg_parity <= pars[i];
      cfg_two_stop <= i[0];
      mask = codes[i][2] ? 9'h1ff : 9'h1ff >> (3'h4 - {1'b0, codes[i][1:0]});
      wr(`UCB_OFS_SHARED, {24'h0, 2'b10, pars[i], i[0], codes[i][1:0], 1'b0});
      wr(`UCB_OFS_CTRL, {24'h0, 5'h1f, codes[i][2], 2'b01});
      far_send;
      for (n = 0; n < 2000 && rx_done_irq !== 1'b1; n++) @(posedge pclk);
      check(32'(rx_done_irq), 32'h1);
      apb(1'b0, `UCB_OFS_STATUS, 32'h0, 1'b0);
      check(r & 32'h9c, 32'h80);
      apb(1'b0, `UCB_OFS_CTRL, 32'h0, 1'b0);
      check(r & 32'h2, 32'(codes[i][2]) << 1);
      rd(`UCB_OFS_DATA, 32'(9'h0ca & mask));
      wr(`UCB_OFS_DATA, 32'hb5);
      for (n = 0; n < 2000 && recv_valid !== 1'b1; n++) @(posedge pclk);
      check(32'(recv_data), 32'(9'h1b5 & mask));
      check(32'(recv_parity_bad), 32'h0);
      check(32'(recv_frame_bad), 32'h0);
      for (n = 0; n < 2000 && tx_done_irq !== 1'b1; n++) @(posedge pclk);
      check(32'(tx_done_irq), 32'h1);
      wr(`UCB_OFS_STATUS, 32'h40);
    end
    global_irq_on <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(tx_empty_irq), 32'h0);
    global_irq_on <= 1'b1;
    repeat (2) @(posedge pclk);
    check(32'(tx_empty_irq), 32'h1);
    wr(`UCB_OFS_STATUS, 32'h01);
    send_data <= 9'h0ca;
    far_send;
    repeat (600) @(posedge pclk);
    check(32'(rx_done_irq), 32'h0);
    send_data <= 9'h1ca;
    far_send;
    for (n = 0; n < 2000 && rx_done_irq !== 1'b1; n++) @(posedge pclk);
    check(32'(rx_done_irq), 32'h1);
    wr(`UCB_OFS_CTRL, 32'h0c);
    check(32'(rx_pin_owned), 32'h0);
    rd(`UCB_OFS_STATUS, 32'h21);
    wr(`UCB_OFS_BAUDL, 32'h06);
    cfg_divisor <= 12'h006;
    cfg_sync <= 1'b1;
    wr(`UCB_OFS_SHARED, 32'he6);
    wr(`UCB_OFS_DATA, 32'h33);
    wr(`UCB_OFS_CTRL, 32'h04);
    check(32'(tx_pin_owned), 32'h1);
    for (n = 0; n < 2000 && recv_valid !== 1'b1; n++) @(posedge pclk);
    check(32'(recv_data), 32'h033);
    for (n = 0; n < 2000 && tx_pin_owned !== 1'b0; n++) @(posedge pclk);
    check(32'(tx_pin_owned), 32'h0);
    port_txd_level <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(link.dev_txd), 32'h0);
    give_verdict;
  end
endmodule // tb
